// [rotrip_assertions.sv]
// Checker for the residual trip top: bus handshakes and trip gating.
// Assumes it is bound to rotrip_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module rotrip_assertions
(
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    // Register bus
    input wire logic s_axi_awvalid_in,
    input wire logic s_axi_awready_out,
    input wire logic s_axi_wvalid_in,
    input wire logic s_axi_wready_out,
    input wire logic [1:0] s_axi_bresp_out,
    input wire logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic s_axi_arvalid_in,
    input wire logic s_axi_arready_out,
    input wire logic [31:0] s_axi_rdata_out,
    input wire logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    // Trip path
    input wire logic function_inhibit_in,
    input wire logic general_trip_out,
    input wire logic irq_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);
    property p_inhibit; function_inhibit_in |=> !general_trip_out; endproperty
    a_inhibit: assert property (p_inhibit) else $error("trip not cleared by inhibit");
    property p_trip_rise; $rose(general_trip_out) |-> !$past(function_inhibit_in); endproperty
    a_trip_rise: assert property (p_trip_rise) else $error("trip rose while inhibited");
    property p_b_hold; s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out); endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
    property p_r_hold; s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
    property p_ar_block; s_axi_rvalid_out |-> !s_axi_arready_out; endproperty
    a_ar_block: assert property (p_ar_block) else $error("read taken while answer pending");
    property p_aw_block; s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out; endproperty
    a_aw_block: assert property (p_aw_block) else $error("write taken while answer pending");
    property p_r_lat; s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out; endproperty
    a_r_lat: assert property (p_r_lat) else $error("read answer late");
    property p_b_lat;
        s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out |-> ##2 s_axi_bvalid_out;
    endproperty
    a_b_lat: assert property (p_b_lat) else $error("write answer late");
    c_trip_on: cover property ($rose(general_trip_out));
    c_trip_off: cover property ($fell(general_trip_out));
    c_irq: cover property ($rose(irq_out));
endmodule // rotrip_assertions
bind rotrip_top rotrip_assertions chk_u (.clk_sys_in, .sys_rst_in, .s_axi_awvalid_in, .s_axi_awready_out,
    .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_arvalid_in,
    .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rvalid_out, .s_axi_rready_in, .function_inhibit_in,
    .general_trip_out, .irq_out);
`default_nettype wire

// [rotrip_core.sv]
// Trip decision core: peak selection, threshold scaling, hysteresis compare.
// Assumes samples arrive with a one-cycle valid strobe on the system clock.
`timescale 1ns/1ps
`default_nettype none
module rotrip_core
    import rotrip_pkg::*;
#(
    parameter int SAMPLE_W = 16,
    parameter int PEAK_WIN = ROTRIP_PEAK_WIN
)
(
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    // Settings
    input wire rotrip_op_t op_mode_in,
    input wire logic [11:0] thr_pct_in,
    input wire logic [15:0] nominal_in,
    input wire logic threshold_x2_in,
    input wire logic function_inhibit_in,
    // Measurements
    input wire logic signed [SAMPLE_W-1:0] sample_in,
    input wire logic sample_valid_in,
    input wire logic [SAMPLE_W-1:0] residual_fundamental_rms_in,
    // Results
    output logic internal_trip_out,
    output logic [SAMPLE_W-1:0] magnitude_out
);
    localparam int CW = $clog2(PEAK_WIN + 1);

    logic [SAMPLE_W-1:0] abs_sample;
    logic [SAMPLE_W-1:0] win_max_r;
    logic [SAMPLE_W-1:0] residual_peak_value_r;
    logic [CW-1:0] win_cnt_r;
    logic [SAMPLE_W-1:0] mag;
    logic [47:0] level_scaled;
    logic [47:0] mag_scaled;
    logic [47:0] reset_scaled;
    logic enabled;
    logic pick;
    logic drop;
    logic trip_r;

    assign abs_sample = sample_in[SAMPLE_W-1] ? SAMPLE_W'(-sample_in) : sample_in;

    // Peak over one window; a cycle is the sample period, not the clock
    always_ff @(posedge clk_sys_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            win_max_r <= '0;
            residual_peak_value_r <= '0;
            win_cnt_r <= '0;
        end
        else if (sample_valid_in)
        begin
            if (win_cnt_r == CW'(PEAK_WIN - 1))
            begin
                win_cnt_r <= '0;
                win_max_r <= abs_sample;
                residual_peak_value_r <= (abs_sample > win_max_r) ? abs_sample : win_max_r;
            end
            else
            begin
                win_cnt_r <= win_cnt_r + CW'(1);
                win_max_r <= (abs_sample > win_max_r) ? abs_sample : win_max_r;
                // Running peak also lifts output so a rising fault is seen at once
                if (abs_sample > residual_peak_value_r)
                    residual_peak_value_r <= abs_sample;
            end
        end
    end

    assign mag = (op_mode_in == ROTRIP_OP_FUND) ? residual_fundamental_rms_in : residual_peak_value_r;
    assign magnitude_out = mag;

    // Compare mag*100 against nominal*pct(*2); no division in the path
    assign level_scaled = 48'(nominal_in) * 48'(thr_pct_in) * (threshold_x2_in ? 48'd2 : 48'd1);
    assign mag_scaled = 48'(mag) * 48'(ROTRIP_PCT_FULL);
    assign reset_scaled = 48'(mag) * 48'(ROTRIP_PCT_FULL) * 48'(ROTRIP_PCT_FULL);
    assign enabled = (op_mode_in != ROTRIP_OP_OFF) && !function_inhibit_in;
    assign pick = mag_scaled > level_scaled;
    // Release when mag < 0.85 * level
    assign drop = reset_scaled < level_scaled * 48'(ROTRIP_RESET_PCT);

    always_ff @(posedge clk_sys_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            trip_r <= 1'b0;
        else if (!enabled)
            trip_r <= 1'b0;
        else if (pick)
            trip_r <= 1'b1;
        else if (drop)
            trip_r <= 1'b0;
    end

    assign internal_trip_out = trip_r;
endmodule // rotrip_core
`default_nettype wire

// [rotrip_fe_model.sv]
// Front-end model: square-wave residual samples and a level RMS value.
// Assumes the bench sets the amplitude; one sample every fourth clock.
`timescale 1ns/1ps
`default_nettype none
module rotrip_fe_model
(
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    // Amplitude request
    input wire logic [15:0] amp_in,
    // Sample stream
    output logic signed [15:0] sample_out,
    output logic valid_out,
    output logic [15:0] rms_out
);
    logic [1:0] cnt_r;
    logic pos_r;
    // Square wave, so peak and RMS both equal the amplitude
    always_ff @(posedge clk_sys_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            cnt_r <= 2'h0;
            pos_r <= 1'b0;
            valid_out <= 1'b0;
            sample_out <= 16'sh0;
        end
        else
        begin
            cnt_r <= cnt_r + 2'h1;
            valid_out <= (cnt_r == 2'h3);
            if (cnt_r == 2'h3)
                pos_r <= !pos_r;
            // Garbage between strobes so nobody relies on a stale value
            sample_out <= (cnt_r == 2'h3) ? (pos_r ? $signed(amp_in) : -$signed(amp_in)) : ~sample_out;
        end
    end
    assign rms_out = amp_in;
endmodule // rotrip_fe_model
`default_nettype wire

// [rotrip_pkg.sv]
// Package of the residual overcurrent trip block: register map, field layout,
// reset values and scaling constants. Used by the AXI4-Lite register file and the core.
// Operation
// - Selector: off, peak, fundamental; resets off
// - Threshold percent 10 to 1000, default 200
// - Trip when magnitude exceeds effective threshold
// - High-range option lifts upper limit to 3000
// - Inhibit input disables function, driven externally
// - Double input doubles effective threshold
// - Single general trip, also readable live
// - Event on each trip change, on or off
// - Trip within 15/25 ms at twice threshold
// - Characteristic applies above tenth of nominal
// - Peak mode derives peak of samples
// - No intentional delay in trip decision
package rotrip_pkg;
    // Register byte offsets
    localparam logic [7:0] ROTRIP_CTRL_OFS = 8'h00;
    localparam logic [7:0] ROTRIP_THR_OFS = 8'h04;
    localparam logic [7:0] ROTRIP_STAT_OFS = 8'h08;
    localparam logic [7:0] ROTRIP_IRQ_OFS = 8'h0C;
    localparam logic [7:0] ROTRIP_MASK_OFS = 8'h10;
    localparam logic [7:0] ROTRIP_NOM_OFS = 8'h14;
    localparam logic [7:0] ROTRIP_MAG_OFS = 8'h18;

    // Operation selector encoding
    typedef enum logic [1:0] {ROTRIP_OP_OFF = 2'h0, ROTRIP_OP_PEAK = 2'h1, ROTRIP_OP_FUND = 2'h2} rotrip_op_t;

    // Threshold limits, percent of nominal
    localparam logic [11:0] ROTRIP_THR_MIN = 12'h00A;
    localparam logic [11:0] ROTRIP_THR_MAX = 12'h3E8;
    localparam logic [11:0] ROTRIP_THR_MAX_EXT = 12'hBB8;
    localparam logic [11:0] ROTRIP_THR_RST = 12'h0C8;
    localparam logic [11:0] ROTRIP_PCT_FULL = 12'h064;
    // Release ratio 0.85 kept as 85 over 100, no divider needed
    localparam logic [6:0] ROTRIP_RESET_PCT = 7'h55;
    // Nominal current default in sample units
    localparam logic [15:0] ROTRIP_NOM_RST = 16'h1000;

    // Interrupt event / control bit positions
    localparam int ROTRIP_EV_ON_BIT = 0;
    localparam int ROTRIP_EV_OFF_BIT = 1;
    localparam int ROTRIP_CTRL_EXT_BIT = 2;

    // Peak hold window, one fundamental period at sample rate
    localparam int ROTRIP_PEAK_WIN = 20;

    localparam logic [1:0] ROTRIP_RESP_OKAY = 2'h0;
    localparam logic [1:0] ROTRIP_RESP_SLVERR = 2'h2;
endpackage

// [rotrip_top.sv]
// Residual overcurrent trip block with AXI4-Lite register file and interrupt.
// Assumes samples and block inputs are synchronous to clk_sys_in.
//
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module rotrip_top
    import rotrip_pkg::*;
#(
    parameter int SAMPLE_W = 16
)
(
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    // Measurement front end
    input wire logic signed [SAMPLE_W-1:0] residual_sample_in,
    input wire logic residual_sample_valid_in,
    input wire logic [SAMPLE_W-1:0] residual_fundamental_rms_in,
    // Binary inputs and option strap
    input wire logic function_inhibit_in,
    input wire logic threshold_x2_in,
    input wire logic high_range_fitted_in,
    // Results
    output logic general_trip_out,
    output logic irq_out
);
    logic [1:0] op_r;
    logic ext_r;
    logic [11:0] thr_r;
    logic [15:0] nom_r;
    logic [1:0] irq_stat_r;
    logic [1:0] irq_mask_r;
    logic aw_held_r;
    logic w_held_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic trip_d_r;
    logic internal_trip;
    logic [SAMPLE_W-1:0] magnitude;
    logic do_write;
    logic do_read;
    logic [11:0] thr_wr;
    logic [11:0] thr_hi;
    logic [1:0] op_wr;
    logic [1:0] ev_set;
    logic [1:0] ev_clr;
    logic wr_hit;
    logic rd_hit;
    logic [31:0] rd_mux;
    rotrip_op_t op_mode;

    // Write fires once both halves held; response slot must be free
    assign s_axi_awready_out = !aw_held_r && !bvalid_r;
    assign s_axi_wready_out = !w_held_r && !bvalid_r;
    assign do_write = aw_held_r && w_held_r && !bvalid_r;
    assign s_axi_arready_out = !rvalid_r;
    assign do_read = s_axi_arvalid_in && !rvalid_r;

    // Threshold clamped to the legal range; high-range option lifts the top
    assign thr_hi = (ext_r && high_range_fitted_in) ? ROTRIP_THR_MAX_EXT : ROTRIP_THR_MAX;
    assign thr_wr = (w_data_r[11:0] < ROTRIP_THR_MIN) ? ROTRIP_THR_MIN :
                    (w_data_r[11:0] > thr_hi) ? thr_hi : w_data_r[11:0];
    // Undefined selector code falls back to off
    assign op_wr = (w_data_r[1:0] == 2'h3) ? ROTRIP_OP_OFF : w_data_r[1:0];
    assign op_mode = rotrip_op_t'(op_r);

    assign wr_hit = (aw_addr_r == ROTRIP_CTRL_OFS) || (aw_addr_r == ROTRIP_THR_OFS) ||
                    (aw_addr_r == ROTRIP_IRQ_OFS) || (aw_addr_r == ROTRIP_MASK_OFS) ||
                    (aw_addr_r == ROTRIP_NOM_OFS);
    function automatic logic wr_hit_rd(input logic [7:0] a);
        wr_hit_rd = (a == ROTRIP_CTRL_OFS) || (a == ROTRIP_THR_OFS) || (a == ROTRIP_STAT_OFS) ||
                    (a == ROTRIP_IRQ_OFS) || (a == ROTRIP_MASK_OFS) || (a == ROTRIP_NOM_OFS) ||
                    (a == ROTRIP_MAG_OFS);
    endfunction

    assign rd_hit = wr_hit_rd(s_axi_araddr_in);

    // Live trip state readable in the status word
    assign rd_mux = (s_axi_araddr_in == ROTRIP_CTRL_OFS) ? {29'h0, ext_r, op_r} :
                    (s_axi_araddr_in == ROTRIP_THR_OFS) ? {20'h0, thr_r} :
                    (s_axi_araddr_in == ROTRIP_STAT_OFS) ? {28'h0, high_range_fitted_in, threshold_x2_in,
                                                            function_inhibit_in, general_trip_out} :
                    (s_axi_araddr_in == ROTRIP_IRQ_OFS) ? {30'h0, irq_stat_r} :
                    (s_axi_araddr_in == ROTRIP_MASK_OFS) ? {30'h0, irq_mask_r} :
                    (s_axi_araddr_in == ROTRIP_NOM_OFS) ? {16'h0, nom_r} :
                    (s_axi_araddr_in == ROTRIP_MAG_OFS) ? 32'(magnitude) : 32'h0000_0000;

    // Trip on and trip off events; set beats a simultaneous clear
    assign ev_set = {trip_d_r & ~internal_trip, internal_trip & ~trip_d_r};
    assign ev_clr = (do_write && aw_addr_r == ROTRIP_IRQ_OFS && w_strb_r[0]) ? w_data_r[1:0] : 2'h0;

    always_ff @(posedge clk_sys_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= ROTRIP_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid_in && s_axi_awready_out)
            begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr_in;
            end
            if (s_axi_wvalid_in && s_axi_wready_out)
            begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata_in;
                w_strb_r <= s_axi_wstrb_in;
            end
            if (do_write)
            begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_hit ? ROTRIP_RESP_OKAY : ROTRIP_RESP_SLVERR;
            end
            else if (bvalid_r && s_axi_bready_in)
                bvalid_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            op_r <= ROTRIP_OP_OFF;
            ext_r <= 1'b0;
            thr_r <= ROTRIP_THR_RST;
            nom_r <= ROTRIP_NOM_RST;
            irq_mask_r <= 2'h0;
        end
        else if (do_write && w_strb_r[0])
        begin
            if (aw_addr_r == ROTRIP_CTRL_OFS)
            begin
                op_r <= op_wr;
                ext_r <= w_data_r[ROTRIP_CTRL_EXT_BIT];
            end
            if (aw_addr_r == ROTRIP_THR_OFS)
                thr_r <= thr_wr;
            if (aw_addr_r == ROTRIP_MASK_OFS)
                irq_mask_r <= w_data_r[1:0];
            if (aw_addr_r == ROTRIP_NOM_OFS)
                nom_r <= w_data_r[15:0];
        end
    end

    always_ff @(posedge clk_sys_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            irq_stat_r <= 2'h0;
            trip_d_r <= 1'b0;
        end
        else
        begin
            trip_d_r <= internal_trip;
            irq_stat_r <= (irq_stat_r & ~ev_clr) | ev_set;
        end
    end

    always_ff @(posedge clk_sys_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= ROTRIP_RESP_OKAY;
        end
        else if (do_read)
        begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_mux;
            rresp_r <= rd_hit ? ROTRIP_RESP_OKAY : ROTRIP_RESP_SLVERR;
        end
        else if (rvalid_r && s_axi_rready_in)
            rvalid_r <= 1'b0;
    end

    rotrip_core #(
        .SAMPLE_W(SAMPLE_W),
        .PEAK_WIN(ROTRIP_PEAK_WIN)
    ) u_core (
        .clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in),
        .op_mode_in(op_mode),
        .thr_pct_in(thr_r),
        .nominal_in(nom_r),
        .threshold_x2_in(threshold_x2_in),
        .function_inhibit_in(function_inhibit_in),
        .sample_in(residual_sample_in),
        .sample_valid_in(residual_sample_valid_in),
        .residual_fundamental_rms_in(residual_fundamental_rms_in),
        .internal_trip_out(internal_trip),
        .magnitude_out(magnitude)
    );

    // Combined trip is the registered decision, no added delay
    assign general_trip_out = internal_trip;
    assign irq_out = |(irq_stat_r & irq_mask_r);

    assign s_axi_bvalid_out = bvalid_r;
    assign s_axi_bresp_out = bresp_r;
    assign s_axi_rvalid_out = rvalid_r;
    assign s_axi_rdata_out = rdata_r;
    assign s_axi_rresp_out = rresp_r;
endmodule // rotrip_top
`default_nettype wire

// [testbench.sv]
// Testbench for the residual trip top: table of trip cases, then reset,
// hysteresis, events, clamping and bus errors. Drives samples via the model.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import rotrip_pkg::*;
;
    typedef struct packed {logic [1:0] op; logic [11:0] thr; logic x2; logic inh; logic [15:0] amp; logic trip;} rotrip_row_t;
    // Nominal is 4096 units, so 100 % trips above 4096
    localparam rotrip_row_t ROWS [9] = '{
        '{2'h1, 12'h064, 1'b0, 1'b0, 16'h1068, 1'b1},
        '{2'h1, 12'h064, 1'b0, 1'b0, 16'h0FA0, 1'b0},
        '{2'h2, 12'h064, 1'b0, 1'b0, 16'h1068, 1'b1},
        '{2'h2, 12'h064, 1'b1, 1'b0, 16'h1068, 1'b0},
        '{2'h2, 12'h064, 1'b1, 1'b0, 16'h2008, 1'b1},
        '{2'h1, 12'h064, 1'b0, 1'b1, 16'h2008, 1'b0},
        '{2'h0, 12'h064, 1'b0, 1'b0, 16'h2008, 1'b0},
        '{2'h1, 12'h00A, 1'b0, 1'b0, 16'h01A4, 1'b1},
        '{2'h2, 12'h005, 1'b0, 1'b0, 16'h0190, 1'b0}};
    localparam logic [7:0] RA [5] = '{ROTRIP_CTRL_OFS, ROTRIP_THR_OFS, ROTRIP_NOM_OFS, ROTRIP_MASK_OFS, ROTRIP_IRQ_OFS};
    localparam logic [31:0] RV [5] = '{32'h0, 32'hC8, 32'h1000, 32'h0, 32'h0};
    logic clk, rst, awvalid, wvalid, bready, arvalid, rready, inh, x2, hrf;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, d;
    logic [1:0] r;
    logic [15:0] amp;
    wire awready, wready, bvalid, arready, rvalid, trip, irq, sv;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire signed [15:0] smp;
    wire [15:0] rms;
    int n_mismatch, total_checks, cyc;

    rotrip_fe_model fe_u (.clk_sys_in(clk), .sys_rst_in(rst), .amp_in(amp), .sample_out(smp), .valid_out(sv),
        .rms_out(rms));
    rotrip_top dut_u (.clk_sys_in(clk), .sys_rst_in(rst), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
        .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
        .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .residual_sample_in(smp),
        .residual_sample_valid_in(sv), .residual_fundamental_rms_in(rms), .function_inhibit_in(inh),
        .threshold_x2_in(x2), .high_range_fitted_in(hrf), .general_trip_out(trip), .irq_out(irq));

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_mismatch++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask

    // Handshake seen at the falling edge equals what the next rising edge samples
    task automatic axw(input logic [7:0] a, input logic [31:0] v);
        logic aw_hit, w_hit, b_hit;
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        b_hit = 1'b0;
        while (!b_hit)
        begin
            @(negedge clk);
            aw_hit = awvalid && awready;
            w_hit = wvalid && wready;
            b_hit = bvalid;
            r = bresp;
            @(posedge clk);
            if (aw_hit)
                awvalid <= 1'b0;
            if (w_hit)
                wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask

    task automatic axr(input logic [7:0] a);
        logic ar_hit, r_hit;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        r_hit = 1'b0;
        while (!r_hit)
        begin
            @(negedge clk);
            ar_hit = arvalid && arready;
            r_hit = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ar_hit)
                arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic wait_trip(input int lim);
        int t;
        t = 0;
        while (trip !== 1'b1 && t < lim)
        begin
            @(negedge clk);
            t++;
        end
    endtask

    initial
    begin
        {awvalid, wvalid, bready, arvalid, rready, inh, x2, hrf} = '0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        amp = '0;
        rst = 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 9; i++)
        begin
            @(posedge clk);
            amp <= '0;
            // Peak needs up to two windows to forget the last row
            settle(200);
            axw(ROTRIP_CTRL_OFS, {30'h0, ROWS[i].op});
            axw(ROTRIP_THR_OFS, {20'h0, ROWS[i].thr});
            x2 <= ROWS[i].x2;
            inh <= ROWS[i].inh;
            amp <= ROWS[i].amp;
            settle(100);
            chk("trip", trip, ROWS[i].trip);
            axr(ROTRIP_STAT_OFS);
            chk("stat", d[0], ROWS[i].trip);
        end
        // Second reset in mid-run with settings changed
        @(posedge clk);
        rst <= 1'b1;
        {amp, inh, x2} <= '0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        chk("trip_rst", trip, 1'b0);
        for (int i = 0; i < 5; i++)
        begin
            axr(RA[i]);
            chk("reset", d, RV[i]);
        end
        axw(ROTRIP_MASK_OFS, 32'h3);
        axw(ROTRIP_THR_OFS, 32'h64);
        axw(ROTRIP_CTRL_OFS, 32'h1);
        amp <= 16'h2000;
        wait_trip(40);
        chk("trip_2x", trip, 1'b1);
        @(posedge clk);
        amp <= 16'h0DAC;
        settle(200);
        chk("hold", trip, 1'b1);
        @(posedge clk);
        amp <= 16'h0D48;
        settle(200);
        chk("release", trip, 1'b0);
        axr(ROTRIP_IRQ_OFS);
        chk("events", d, 32'h3);
        chk("irq", irq, 1'b1);
        axw(ROTRIP_IRQ_OFS, 32'h3);
        settle(1);
        chk("irq_clr", irq, 1'b0);
        @(posedge clk);
        amp <= 16'h2000;
        wait_trip(40);
        chk("retrip", trip, 1'b1);
        @(posedge clk);
        inh <= 1'b1;
        settle(2);
        chk("inhibit", trip, 1'b0);
        @(posedge clk);
        inh <= 1'b0;
        axw(ROTRIP_THR_OFS, 32'h5DC);
        axr(ROTRIP_THR_OFS);
        chk("thr_max", d, 32'h3E8);
        @(posedge clk);
        hrf <= 1'b1;
        axw(ROTRIP_CTRL_OFS, 32'h4);
        axw(ROTRIP_THR_OFS, 32'hDAC);
        axr(ROTRIP_THR_OFS);
        chk("thr_ext", d, 32'hBB8);
        axw(ROTRIP_CTRL_OFS, 32'h3);
        axr(ROTRIP_CTRL_OFS);
        chk("op_code3", d, 32'h0);
        axw(8'h40, 32'h1);
        chk("bresp", r, ROTRIP_RESP_SLVERR);
        axr(8'h40);
        chk("rresp", r, ROTRIP_RESP_SLVERR);
        chk("rdata", d, 32'h0);
        conclude();
    end
endmodule // testbench
`default_nettype wire
